// ==== dv/terminal_equipment.sv ====
/* load model wired to the relay and open-collector outputs: measures
   pulse half periods and counts main relay on-cycles.
   Assumes the same clock as the mux and a passive load. */
`timescale 1ns/100ps
module terminal_equipment (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic multiplexed_output_i,
    input wire logic main_relay_i
);
    int min_half = 32'h7FFFFFFF;
    int edges = 0;
    int run = 0;
    int relay_on = 0;
    logic seen = 1'b0;
    logic last = 1'b0;

    // call off the clock edge to avoid racing the monitor
    task automatic clear();
        min_half = 32'h7FFFFFFF;
        edges = 0;
        relay_on = 0;
        seen = 1'b0;
    endtask

    always @(posedge clk_i)
    begin
        if (!rst_i && multiplexed_output_i !== last)
        begin
            // first interval after clear is partial, skip it
            if (seen && run < min_half)
                min_half = run;
            seen = 1'b1;
            edges++;
            run = 1;
        end
        else
            run++;
        if (main_relay_i === 1'b1)
            relay_on++;
        last = multiplexed_output_i;
    end
endmodule

// ==== dv/testbench.sv ====
/* self-checking bench of the output terminal mux: reset values, pulse
   clamp, every function code, sequencer pulse.
   Assumes the register map and latencies of the design package. */
`timescale 1ns/100ps
module testbench
    import output_mux_pkg::*;
;
    localparam int SEQ_LEN = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    reg_req_t req_i = '0;
    logic [DATA_W-1:0] rdata_o;
    drive_flags_t flags_i = '0;
    drive_values_t values_i = '0;
    logic [FREQ_W-1:0] pulse_freq_req_i = '0;
    logic multiplexed_output_o;
    logic main_relay_o;
    logic extension_relay_o;
    logic second_open_collector_output_o;
    logic extension_output_o;
    logic [4:0] outs;
    int err_count = 0;
    int total_checks = 0;
    integer seed = 32'h65056189;
    logic [DATA_W-1:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic [DATA_W-1:0] sp[4];
    logic [4:0] comm;

    always #20 clk_i = ~clk_i;

    assign outs = {extension_output_o, second_open_collector_output_o,
        extension_relay_o, main_relay_o, multiplexed_output_o};

    output_terminal_mux #(.SEQ_PULSE_LEN(SEQ_LEN)) i_dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .req_i(req_i),
        .rdata_o(rdata_o),
        .flags_i(flags_i),
        .values_i(values_i),
        .pulse_freq_req_i(pulse_freq_req_i),
        .multiplexed_output_o(multiplexed_output_o),
        .main_relay_o(main_relay_o),
        .extension_relay_o(extension_relay_o),
        .second_open_collector_output_o(second_open_collector_output_o),
        .extension_output_o(extension_output_o)
    );

    terminal_equipment i_equip (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .multiplexed_output_i(multiplexed_output_o),
        .main_relay_i(main_relay_o)
    );

    task automatic check(input string what, input logic [DATA_W-1:0] got,
        input logic [DATA_W-1:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one idle cycle after each strobe keeps drives one per time step
    task automatic wr(input logic [7:0] a, input logic [DATA_W-1:0] d);
        req_i <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
        req_i <= '0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [DATA_W-1:0] e);
        exp_q.push_back(e);
        req_i <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk_i);
        req_i <= '0;
        @(posedge clk_i);
    endtask

    always @(posedge clk_i)
    begin
        if (rd_seen)
            check("rdata", rdata_o, exp_q.pop_front());
        rd_seen <= req_i.rd;
    end

    function automatic logic fn(input logic [4:0] c, input int i);
        case (c)
            5'h01: return flags_i.running;
            5'h02: return flags_i.fault_stop;
            5'h03: return flags_i.frequency_level_flag_one;
            5'h04: return flags_i.freq_reached;
            5'h05: return flags_i.running && values_i.out_freq == 16'h0000;
            5'h06: return flags_i.motor_ol_warn;
            5'h07: return flags_i.drive_ol_warn;
            5'h08: return values_i.count_value >= sp[0];
            5'h09: return values_i.count_value >= sp[1];
            5'h0A: return values_i.length_value > sp[2];
            5'h0C: return values_i.run_time > sp[3];
            5'h0D: return flags_i.freq_limited;
            5'h0E: return flags_i.torque_limited;
            5'h0F: return flags_i.ready;
            5'h10: return values_i.analog_input_one > values_i.analog_input_two;
            5'h11: return flags_i.upper_limit_reached;
            5'h12: return flags_i.lower_limit_reached && flags_i.running;
            5'h13: return flags_i.undervoltage;
            5'h14: return comm[i];
            default: return 1'b0;
        endcase
    endfunction

    task automatic seq_run(input int gap, input int exp_on);
        #5 i_equip.clear();
        @(posedge clk_i);
        for (int p = 0; p < 2; p++)
        begin
            flags_i <= 13'h0040;
            @(posedge clk_i);
            flags_i <= '0;
            repeat (gap) @(posedge clk_i);
        end
        repeat (3 * SEQ_LEN) @(posedge clk_i);
        check("seq on", 16'(i_equip.relay_on), 16'(exp_on));
    endtask

    initial
    begin : main
        logic [4:0] e;
        drive_values_t v;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(ADDR_MODE, 16'h0000);
        for (int i = 0; i < NUM_OUTPUTS; i++)
            rd(ADDR_FUNC_BASE + 8'(i), {11'h000, FUNC_RESET[i]});
        rd(ADDR_MAX_FREQ, 16'h2710);
        rd(8'h0D, 16'h0000);
        wr(ADDR_MAX_FREQ, 16'h0000);
        rd(ADDR_MAX_FREQ, 16'h0001);
        wr(ADDR_MAX_FREQ, 16'hFFFF);
        rd(ADDR_MAX_FREQ, 16'h2710);
        // request far above the ceiling: the clamp must hold it
        pulse_freq_req_i <= 14'h3FFF;
        #5 i_equip.clear();
        repeat (1000) @(posedge clk_i);
        check("half", 16'(i_equip.min_half >= MIN_HALF_CYCLES), 16'h0001);
        check("toggling", 16'(i_equip.edges > 4), 16'h0001);
        wr(ADDR_MAX_FREQ, 16'h1388);
        #5 i_equip.clear();
        repeat (2000) @(posedge clk_i);
        check("half set", 16'(i_equip.min_half >= 250), 16'h0001);
        wr(ADDR_MODE, 16'h0001);
        for (int k = 0; k < 4; k++)
        begin
            sp[k] = 16'($random(seed));
            wr(ADDR_SET_COUNT + 8'(k), sp[k]);
        end
        comm = 5'($random(seed));
        wr(ADDR_COMM_LEVEL, {11'h000, comm});
        for (int c = 0; c < 32; c++)
        begin
            for (int i = 0; i < NUM_OUTPUTS; i++)
                wr(ADDR_FUNC_BASE + 8'(i), 16'((c + i) % 32));
            repeat (3)
            begin
                // sequencer done kept low; its pulse is tested apart
                flags_i <= drive_flags_t'(13'($random(seed)) & 13'h1FBF);
                v = drive_values_t'({$random(seed), $random(seed),
                    $random(seed)});
                if (v[0])
                    v.out_freq = 16'h0000;
                values_i <= v;
                repeat (4) @(posedge clk_i);
                for (int i = 0; i < NUM_OUTPUTS; i++)
                    e[i] = fn(5'(c + i), i);
                check("outs", {11'h000, outs}, {11'h000, e});
                rd(ADDR_STATUS, {9'h000, e[0], 1'b0, e});
            end
        end
        for (int i = 0; i < NUM_OUTPUTS; i++)
            wr(ADDR_FUNC_BASE + 8'(i), 16'h000B);
        // two separate cycle ends give two full pulses
        seq_run(3 * SEQ_LEN, 2 * SEQ_LEN);
        seq_run(9, 10 + SEQ_LEN);
        final_report();
    end

    // run needs about 4200 cycles; margin of over four
    initial
    begin
        #(40 * 20000);
        err_count++;
        final_report();
    end
endmodule

// ==== src/output_mux_pkg.sv ====
/*
 * Package of the drive output terminal function mux: register map, field
 * widths, reset values, function codes and timing counts.
 * Assumes a 25 MHz system clock shared with the drive controller.
 */
package output_mux_pkg;

    localparam int CLK_HZ = 25_000_000;

    // register word addresses
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_FUNC_BASE = 8'h01;
    localparam logic [7:0] ADDR_MAX_FREQ = 8'h06;
    localparam logic [7:0] ADDR_COMM_LEVEL = 8'h07;
    localparam logic [7:0] ADDR_SET_COUNT = 8'h08;
    localparam logic [7:0] ADDR_DESIG_COUNT = 8'h09;
    localparam logic [7:0] ADDR_LENGTH_SP = 8'h0A;
    localparam logic [7:0] ADDR_RUNTIME_SP = 8'h0B;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    localparam int NUM_OUTPUTS = 5;
    localparam int FUNC_W = 5;
    localparam int DATA_W = 16;
    localparam int FREQ_W = 14;

    // output indices
    localparam int OUT_SWITCH = 0;
    localparam int OUT_MAIN_RELAY = 1;
    localparam int OUT_EXT_RELAY = 2;
    localparam int OUT_SECOND_OC = 3;
    localparam int OUT_EXT_DO = 4;

    localparam logic MODE_PULSE = 1'b0;
    localparam logic MODE_RESET = MODE_PULSE;

    // function code reset values, output 0 first
    localparam logic [FUNC_W-1:0] FUNC_RESET [NUM_OUTPUTS] =
        '{5'h00, 5'h02, 5'h00, 5'h01, 5'h04};

    typedef enum logic [FUNC_W-1:0] {
        FN_NONE, FN_RUNNING, FN_FAULT_STOP, FN_FREQUENCY_LEVEL_FLAG_ONE, FN_FREQ_REACHED,
        FN_ZERO_SPEED, FN_MOTOR_OL_WARN, FN_DRIVE_OL_WARN, FN_SET_COUNT,
        FN_DESIG_COUNT, FN_LENGTH, FN_SEQ_DONE, FN_RUN_TIME,
        FN_FREQ_LIMITED, FN_TORQUE_LIMITED, FN_READY, FN_AI1_GT_AI2,
        FN_UPPER_LIMIT, FN_LOWER_LIMIT, FN_UNDERVOLTAGE, FN_COMM
    } func_code_t;

    // pulse frequency in units of 0.01 kHz (10 Hz)
    localparam int FREQ_UNIT_HZ = 10;
    localparam logic [FREQ_W-1:0] MAX_FREQ_MIN = 14'h0001;
    localparam logic [FREQ_W-1:0] MAX_FREQ_MAX = 14'h2710;
    localparam logic [FREQ_W-1:0] MAX_FREQ_RESET = MAX_FREQ_MAX;
    localparam int PULSE_ACC_W = 21;
    localparam logic [PULSE_ACC_W-1:0] HALF_PERIOD_ACC =
        PULSE_ACC_W'(CLK_HZ / (2 * FREQ_UNIT_HZ));
    // shortest half period at the frequency ceiling, in cycles
    localparam int MIN_HALF_CYCLES =
        CLK_HZ / (2 * FREQ_UNIT_HZ * 10000);

    localparam int SEQ_PULSE_MS = 250;
    localparam int SEQ_PULSE_CYCLES = CLK_HZ / 1000 * SEQ_PULSE_MS;
    localparam int SEQ_CNT_W = 23;

    typedef struct packed {
        logic running;
        logic fault_stop;
        logic frequency_level_flag_one;
        logic freq_reached;
        logic motor_ol_warn;
        logic drive_ol_warn;
        logic seq_cycle_done;
        logic freq_limited;
        logic torque_limited;
        logic ready;
        logic upper_limit_reached;
        logic lower_limit_reached;
        logic undervoltage;
    } drive_flags_t;

    typedef struct packed {
        logic [DATA_W-1:0] out_freq;
        logic [DATA_W-1:0] count_value;
        logic [DATA_W-1:0] length_value;
        logic [DATA_W-1:0] run_time;
        logic [DATA_W-1:0] analog_input_one;
        logic [DATA_W-1:0] analog_input_two;
    } drive_values_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// ==== src/output_terminal_mux.sv ====
/*
 * Drive output terminal function mux: five digital outputs each pick one
 * drive condition by a function code; the multiplexed terminal is either a
 * clamped pulse generator or the first switch output.
 * Assumes status inputs come from logic on the same clock, and a register
 * master that reads data one cycle after the read strobe.
 */
// Function
// - mode setting: 0 pulse, else switch; reset pulse
// - pulse frequency never above 100 kHz
// - five function codes with fixed reset defaults
// - code 0 keeps output inactive
// - code 1 asserts while running, zero included
// - code 2 asserts on fault stop
// - codes 3, 4 follow level and reached flags
// - code 5 running at zero, off when stopped
// - code 6 follows motor overload pre-warning
// - code 7 asserts ahead of drive overload trip
// - codes 8, 9 on count values reached
// - code 10 when length exceeds setpoint
// - code 11 gives 250 ms pulse per cycle
// - code 12 when running time exceeds setpoint
// - code 13 asserts when frequency limited
// - code 14 asserts on torque limit stall
// - code 15 asserts when ready to run
// - code 16 asserts while input one exceeds two
// - code 17 on upper frequency limit reached
// - code 18 on lower limit, off when stopped
// - code 19 asserts during undervoltage
// - code 20 follows communication written level
// - max pulse setting clamped, pulse within it
`timescale 1ns/100ps
module output_terminal_mux
    import output_mux_pkg::*;
#(
    parameter int SEQ_PULSE_LEN = SEQ_PULSE_CYCLES
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire reg_req_t req_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire drive_flags_t flags_i,
    input wire drive_values_t values_i,
    input wire logic [FREQ_W-1:0] pulse_freq_req_i,
    output logic multiplexed_output_o,
    output logic main_relay_o,
    output logic extension_relay_o,
    output logic second_open_collector_output_o,
    output logic extension_output_o
);

    typedef struct packed {
        logic multiplexed_output_mode_param;
        logic [NUM_OUTPUTS-1:0][FUNC_W-1:0] func;
        logic [FREQ_W-1:0] max_pulse_frequency_param;
        logic [NUM_OUTPUTS-1:0] comm_level;
        logic [DATA_W-1:0] set_count_value;
        logic [DATA_W-1:0] designated_count_value;
        logic [DATA_W-1:0] length_setpoint;
        logic [DATA_W-1:0] running_time_setpoint;
        logic [NUM_OUTPUTS-1:0] outs;
        logic [SEQ_CNT_W-1:0] seq_cnt;
        logic [PULSE_ACC_W-1:0] acc;
        logic pulse_level;
        logic mux_out;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t s;
    state_t next_s;

    function automatic logic pick(input logic [FUNC_W-1:0] code,
                                  input logic comm, input logic seq_on);
        logic stopped;
        logic zero_freq;
        stopped = !flags_i.running;
        zero_freq = values_i.out_freq == '0;
        pick = 1'b0;
        case (code)
            FN_NONE: pick = 1'b0;
            FN_RUNNING: pick = flags_i.running;
            FN_FAULT_STOP: pick = flags_i.fault_stop;
            FN_FREQUENCY_LEVEL_FLAG_ONE: pick = flags_i.frequency_level_flag_one;
            FN_FREQ_REACHED: pick = flags_i.freq_reached;
            FN_ZERO_SPEED: pick = !stopped && zero_freq;
            FN_MOTOR_OL_WARN: pick = flags_i.motor_ol_warn;
            // controller raises this 10 s before its own trip
            FN_DRIVE_OL_WARN: pick = flags_i.drive_ol_warn;
            FN_SET_COUNT:
                pick = values_i.count_value >= s.set_count_value;
            FN_DESIG_COUNT:
                pick = values_i.count_value >=
                    s.designated_count_value;
            FN_LENGTH:
                pick = values_i.length_value > s.length_setpoint;
            FN_SEQ_DONE: pick = seq_on;
            FN_RUN_TIME:
                pick = values_i.run_time > s.running_time_setpoint;
            FN_FREQ_LIMITED: pick = flags_i.freq_limited;
            FN_TORQUE_LIMITED: pick = flags_i.torque_limited;
            FN_READY: pick = flags_i.ready;
            FN_AI1_GT_AI2:
                pick = values_i.analog_input_one >
                    values_i.analog_input_two;
            FN_UPPER_LIMIT: pick = flags_i.upper_limit_reached;
            FN_LOWER_LIMIT:
                pick = flags_i.lower_limit_reached && !stopped;
            FN_UNDERVOLTAGE: pick = flags_i.undervoltage;
            FN_COMM: pick = comm;
            default: pick = 1'b0;
        endcase
    endfunction

    always_comb
    begin
        logic [FREQ_W-1:0] freq;
        logic [FREQ_W-1:0] wfreq;
        logic [PULSE_ACC_W-1:0] sum;
        logic seq_on;
        next_s = s;
        next_s.rdata = '0;
        freq = '0;
        wfreq = '0;
        sum = '0;
        seq_on = s.seq_cnt != '0;

        if (req_i.wr)
        begin
            wfreq = req_i.wdata[FREQ_W-1:0];
            case (req_i.addr)
                ADDR_MODE: next_s.multiplexed_output_mode_param =
                    req_i.wdata != '0;
                ADDR_MAX_FREQ:
                begin
                    // out-of-range writes saturate, never wrap
                    if (req_i.wdata < DATA_W'(MAX_FREQ_MIN))
                        next_s.max_pulse_frequency_param =
                            MAX_FREQ_MIN;
                    else if (req_i.wdata > DATA_W'(MAX_FREQ_MAX))
                        next_s.max_pulse_frequency_param =
                            MAX_FREQ_MAX;
                    else
                        next_s.max_pulse_frequency_param = wfreq;
                end
                ADDR_COMM_LEVEL: next_s.comm_level =
                    req_i.wdata[NUM_OUTPUTS-1:0];
                ADDR_SET_COUNT: next_s.set_count_value = req_i.wdata;
                ADDR_DESIG_COUNT:
                    next_s.designated_count_value = req_i.wdata;
                ADDR_LENGTH_SP: next_s.length_setpoint = req_i.wdata;
                ADDR_RUNTIME_SP: next_s.running_time_setpoint = req_i.wdata;
                default:
                begin
                    for (int i = 0; i < NUM_OUTPUTS; i++)
                        if (req_i.addr == ADDR_FUNC_BASE + 8'(i))
                            next_s.func[i] = req_i.wdata[FUNC_W-1:0];
                end
            endcase
        end

        if (req_i.rd)
        begin
            case (req_i.addr)
                ADDR_MODE: next_s.rdata =
                    DATA_W'(s.multiplexed_output_mode_param);
                ADDR_MAX_FREQ: next_s.rdata =
                    DATA_W'(s.max_pulse_frequency_param);
                ADDR_COMM_LEVEL: next_s.rdata = DATA_W'(s.comm_level);
                ADDR_SET_COUNT: next_s.rdata = s.set_count_value;
                ADDR_DESIG_COUNT: next_s.rdata = s.designated_count_value;
                ADDR_LENGTH_SP: next_s.rdata = s.length_setpoint;
                ADDR_RUNTIME_SP: next_s.rdata = s.running_time_setpoint;
                ADDR_STATUS: next_s.rdata =
                    DATA_W'({s.mux_out, s.pulse_level, s.outs});
                default:
                begin
                    for (int i = 0; i < NUM_OUTPUTS; i++)
                        if (req_i.addr == ADDR_FUNC_BASE + 8'(i))
                            next_s.rdata = DATA_W'(s.func[i]);
                end
            endcase
        end

        // a new cycle end restarts the pulse rather than extending it
        if (flags_i.seq_cycle_done)
            next_s.seq_cnt = SEQ_CNT_W'(SEQ_PULSE_LEN);
        else if (seq_on)
            next_s.seq_cnt = s.seq_cnt - 1'b1;

        // clamp the request to the setting, the setting to 100 kHz
        freq = pulse_freq_req_i > s.max_pulse_frequency_param ?
            s.max_pulse_frequency_param : pulse_freq_req_i;
        if (s.multiplexed_output_mode_param != MODE_PULSE)
        begin
            next_s.acc = '0;
            next_s.pulse_level = 1'b0;
        end
        else
        begin
            sum = s.acc + PULSE_ACC_W'(freq);
            if (sum >= HALF_PERIOD_ACC)
            begin
                next_s.acc = sum - HALF_PERIOD_ACC;
                next_s.pulse_level = !s.pulse_level;
            end
            else
                next_s.acc = sum;
        end

        for (int i = 0; i < NUM_OUTPUTS; i++)
            next_s.outs[i] = pick(s.func[i], s.comm_level[i], seq_on);
        next_s.mux_out = s.multiplexed_output_mode_param == MODE_PULSE ?
            s.pulse_level : s.outs[OUT_SWITCH];
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.multiplexed_output_mode_param <= MODE_RESET;
            for (int i = 0; i < NUM_OUTPUTS; i++)
                s.func[i] <= FUNC_RESET[i];
            s.max_pulse_frequency_param <= MAX_FREQ_RESET;
        end
        else
            s <= next_s;
    end

    assign rdata_o = s.rdata;
    assign multiplexed_output_o = s.mux_out;
    assign main_relay_o = s.outs[OUT_MAIN_RELAY];
    assign extension_relay_o = s.outs[OUT_EXT_RELAY];
    assign second_open_collector_output_o = s.outs[OUT_SECOND_OC];
    assign extension_output_o = s.outs[OUT_EXT_DO];

    // helper: cycles since the last pulse edge, saturating
    logic [7:0] half_cnt;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            half_cnt <= '0;
        else if (s.pulse_level != next_s.pulse_level)
            half_cnt <= '0;
        else if (half_cnt != 8'hFF)
            half_cnt <= half_cnt + 1'b1;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [FUNC_W-1:0] main_fn;
    assign main_fn = s.func[OUT_MAIN_RELAY];

    sequence seq_done_with_code11;
        flags_i.seq_cycle_done && main_fn == FN_SEQ_DONE;
    endsequence
    sequence seq_pulse_held;
        main_relay_o [*8];
    endsequence

    AST_MODE_ROUTE: assert property (
        s.multiplexed_output_mode_param != MODE_PULSE
        |=> multiplexed_output_o == $past(s.outs[OUT_SWITCH]))
        else $error("switch mode does not route the switch output");
    AST_PULSE_MIN_HALF: assert property (
        s.multiplexed_output_mode_param == MODE_PULSE && s.pulse_level &&
        !next_s.pulse_level |-> half_cnt >= 8'(MIN_HALF_CYCLES - 1))
        else $error("pulse half period shorter than 100 kHz allows");
    AST_CODE0_OFF: assert property (
        main_fn == FN_NONE |=> !main_relay_o)
        else $error("code 0 output not inactive");
    AST_RUNNING: assert property (
        main_fn == FN_RUNNING |=> main_relay_o == $past(flags_i.running))
        else $error("code 1 output does not follow running");
    AST_ZERO_SPEED_STOP: assert property (
        main_fn == FN_ZERO_SPEED && !flags_i.running |=> !main_relay_o)
        else $error("code 5 output on while stopped");
    AST_SEQ_PULSE: assert property (
        seq_done_with_code11 ##1 (main_fn == FN_SEQ_DONE) [*8]
        |-> ##1 seq_pulse_held)
        else $error("cycle done pulse not held");
    AST_LOWER_STOP: assert property (
        main_fn == FN_LOWER_LIMIT && !flags_i.running |=> !main_relay_o)
        else $error("code 18 output on while stopped");
    AST_COMM: assert property (
        main_fn == FN_COMM
        |=> main_relay_o == $past(s.comm_level[OUT_MAIN_RELAY]))
        else $error("code 20 output does not follow written level");
    AST_MAX_RANGE: assert property (
        s.max_pulse_frequency_param >= MAX_FREQ_MIN &&
        s.max_pulse_frequency_param <= MAX_FREQ_MAX)
        else $error("max pulse setting out of range");
    AST_BAD_CODE: assert property (
        main_fn > FN_COMM |=> !main_relay_o)
        else $error("unsupported code drives output");
    AST_UNDERVOLT: assert property (
        main_fn == FN_UNDERVOLTAGE && flags_i.undervoltage
        |=> main_relay_o)
        else $error("code 19 output off during undervoltage");

endmodule
